// [rtl/lcv_pkg.sv]
// Constants shared by the two-channel light conversion sequencer and its channel counters.
// Assumes a single 20 MHz core clock from which the integration oscillator is derived.
package lcv_pkg;

  // Core clock and nominal integration oscillator.
  localparam int unsigned CORE_CLK_HZ       = 20000000;
  localparam int unsigned OSC_FREQ_HZ       = 735000;
  // Rounded down, so the derived oscillator runs slightly fast rather than slow.
  localparam int unsigned OSC_DIV_CYCLES    = CORE_CLK_HZ / OSC_FREQ_HZ;
  localparam logic [4:0]  OSC_DIV_LAST      = 5'(OSC_DIV_CYCLES - 1);

  // Integration length: a multiple of a base count of oscillator cycles.
  localparam int unsigned INTEG_UNIT_DEFAULT = 918;
  localparam int unsigned LEN_W              = 20;
  localparam logic [8:0]  MULT_SHORT         = 9'h00b;
  localparam logic [8:0]  MULT_MEDIUM        = 9'h051;
  localparam logic [8:0]  MULT_LONG          = 9'h142;

  localparam logic [1:0]  TIME_SHORT         = 2'h0;
  localparam logic [1:0]  TIME_MEDIUM        = 2'h1;
  localparam logic [1:0]  TIME_LONG          = 2'h2;

  // Channel count format and limits.
  localparam int unsigned DATA_W             = 16;
  localparam logic [15:0] DATA_RESET         = 16'h0000;
  localparam logic [19:0] FULL_SCALE_CAP     = 20'h0ffff;
  localparam logic [19:0] FULL_SCALE_OFFSET  = 20'h00002;
  localparam logic [1:0]  COUNT_OFFSET       = 2'h2;

  // Persistence filter.
  localparam int unsigned PERSIST_W          = 4;
  localparam logic [3:0]  PERSIST_EVERY      = 4'h0;
  localparam logic [3:0]  PERSIST_MAX        = 4'hf;

  // Three-level address select pin and the bus addresses it picks.
  localparam logic [1:0]  ADDR_LVL_GND       = 2'h0;
  localparam logic [1:0]  ADDR_LVL_FLOAT     = 2'h1;
  localparam logic [1:0]  ADDR_LVL_VDD       = 2'h2;
  localparam logic [6:0]  BUS_ADDR_GND       = 7'h29;
  localparam logic [6:0]  BUS_ADDR_FLOAT     = 7'h39;
  localparam logic [6:0]  BUS_ADDR_VDD       = 7'h49;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INTEG = 3'b010,
    ST_XFER  = 3'b100
  } lcv_state_e;

endpackage

// [rtl/lcv_chan_counter.sv]
// One integrating channel: counts photo charge quanta during an integration window.
// Assumes photoPulse is a synchronous one-cycle pulse and oscTick a one-cycle enable.
`timescale 1ns/1ns
module lcv_chan_counter (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clearCount,
  input  wire logic        countEnable,
  input  wire logic        oscTick,
  input  wire logic        photoPulse,
  input  wire logic [15:0] fullScale,
  output logic      [15:0] count
);

  logic        phase_r;
  logic        slotReady_r;
  logic        pulsePend_r;
  logic [1:0]  offsetLeft_r;
  logic [15:0] count_r;
  logic        slotTick;
  logic        accept;

  // A count slot opens on every odd oscillator tick. The last slot of a window then
  // still lands its count before the final even tick closes the window.
  assign slotTick = oscTick & ~phase_r;
  assign accept   = countEnable & pulsePend_r & slotReady_r;
  assign count    = count_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n || clearCount) begin
      phase_r <= 1'b0;
    end else if (oscTick) begin
      phase_r <= ~phase_r;
    end
  end

  // A new slot or pulse arriving with an accept is kept, so set wins.
  always_ff @(posedge core_clk) begin
    if (!rst_n || clearCount) begin
      slotReady_r <= 1'b0;
      pulsePend_r <= 1'b0;
    end else begin
      slotReady_r <= slotTick | (slotReady_r & ~accept);
      pulsePend_r <= (countEnable & photoPulse) | (pulsePend_r & ~accept);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || clearCount) begin
      offsetLeft_r <= lcv_pkg::COUNT_OFFSET;
      count_r      <= lcv_pkg::DATA_RESET;
    end else if (accept) begin
      if (offsetLeft_r != 2'h0) begin
        offsetLeft_r <= offsetLeft_r - 2'h1;
      end else if (count_r < fullScale) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

endmodule

// [rtl/lcv_conv_top.sv]
// Conversion sequencer, double-buffered result registers and threshold interrupt.
// Assumes configuration inputs are held stable by the bus front end that owns them.
`timescale 1ns/1ns
module lcv_conv_top #(
  parameter int unsigned INTEG_UNIT = lcv_pkg::INTEG_UNIT_DEFAULT
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        powerOn,
  input  wire logic [1:0]  timingCode,
  input  wire logic [15:0] threshLow,
  input  wire logic [15:0] threshHigh,
  input  wire logic [3:0]  persistCode,
  input  wire logic        intClear,
  input  wire logic        readHold,
  input  wire logic [1:0]  photoPulse,
  input  wire logic [1:0]  addrSelLevel,
  output logic      [15:0] broadbandData,
  output logic      [15:0] infraredData,
  output logic             dataValid,
  output logic             intPinOut,
  output logic             intPinOe,
  output logic      [6:0]  deviceAddr
);

  function automatic logic [19:0] lenFor(input logic [1:0] code);
    logic [8:0] mult;
    unique case (code)
      lcv_pkg::TIME_SHORT:  mult = lcv_pkg::MULT_SHORT;
      lcv_pkg::TIME_MEDIUM: mult = lcv_pkg::MULT_MEDIUM;
      default:              mult = lcv_pkg::MULT_LONG;
    endcase
    return 20'(32'(mult) * INTEG_UNIT);
  endfunction

  function automatic logic [15:0] fullScaleFor(input logic [19:0] len);
    logic [19:0] half;
    half = (len >> 1) - lcv_pkg::FULL_SCALE_OFFSET;
    if (half > lcv_pkg::FULL_SCALE_CAP) begin
      return 16'hffff;
    end
    return half[15:0];
  endfunction

  function automatic logic [6:0] addrFor(input logic [1:0] level);
    unique case (level)
      lcv_pkg::ADDR_LVL_GND: return lcv_pkg::BUS_ADDR_GND;
      lcv_pkg::ADDR_LVL_VDD: return lcv_pkg::BUS_ADDR_VDD;
      default:               return lcv_pkg::BUS_ADDR_FLOAT;
    endcase
  endfunction

  lcv_pkg::lcv_state_e state_r;
  lcv_pkg::lcv_state_e state_nxt;
  logic [4:0]  divCnt_r;
  logic        oscTick_r;
  logic [19:0] oscCnt_r;
  logic [19:0] curLen_r;
  logic [15:0] fullScale_r;
  logic [15:0] chanCount [2];
  logic        integrating;
  logic        xfer;
  logic        cycleDone;
  logic [15:0] shadowBb_r;
  logic [15:0] shadowIr_r;
  logic        shadowFull_r;
  logic [15:0] broadbandData_r;
  logic [15:0] infraredData_r;
  logic        dataValid_r;
  logic [3:0]  persistCnt_r;
  logic [3:0]  persist_nxt;
  logic        outside;
  logic        fire;
  logic        intActive_r;
  logic        intPinOut_r;
  logic [6:0]  deviceAddr_r;

  assign integrating = (state_r == lcv_pkg::ST_INTEG);
  assign xfer        = (state_r == lcv_pkg::ST_XFER);
  assign cycleDone   = oscTick_r && (oscCnt_r == curLen_r - 20'h00001);

  // Oscillator stand-in: one-cycle enable every OSC_DIV_CYCLES core cycles, just above the nominal rate.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt_r  <= 5'h00;
      oscTick_r <= 1'b0;
    end else if (divCnt_r == lcv_pkg::OSC_DIV_LAST) begin
      divCnt_r  <= 5'h00;
      oscTick_r <= 1'b1;
    end else begin
      divCnt_r  <= divCnt_r + 5'h01;
      oscTick_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lcv_pkg::ST_IDLE: begin
        if (powerOn) begin
          state_nxt = lcv_pkg::ST_INTEG;
        end
      end
      lcv_pkg::ST_INTEG: begin
        if (!powerOn) begin
          state_nxt = lcv_pkg::ST_IDLE;
        end else if (cycleDone) begin
          state_nxt = lcv_pkg::ST_XFER;
        end
      end
      lcv_pkg::ST_XFER: begin
        state_nxt = powerOn ? lcv_pkg::ST_INTEG : lcv_pkg::ST_IDLE;
      end
      default: state_nxt = lcv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= lcv_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The timing code is captured only between cycles so a change never splits one.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oscCnt_r    <= 20'h00000;
      curLen_r    <= lenFor(lcv_pkg::TIME_LONG);
      fullScale_r <= fullScaleFor(lenFor(lcv_pkg::TIME_LONG));
    end else if (!integrating) begin
      oscCnt_r    <= 20'h00000;
      curLen_r    <= lenFor(timingCode);
      fullScale_r <= fullScaleFor(lenFor(timingCode));
    end else if (oscTick_r) begin
      oscCnt_r <= oscCnt_r + 20'h00001;
    end
  end

  // Both channels share one clear and one enable, so their windows coincide.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    lcv_chan_counter u_chan (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .clearCount  (!integrating),
      .countEnable (integrating),
      .oscTick     (oscTick_r),
      .photoPulse  (photoPulse[ch]),
      .fullScale   (fullScale_r),
      .count       (chanCount[ch])
    );
  end

  // Shadow stage; the visible registers load whole words from it only while no
  // read is in progress; a hold across several results keeps only the newest of them.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shadowBb_r <= lcv_pkg::DATA_RESET;
      shadowIr_r <= lcv_pkg::DATA_RESET;
    end else if (cycleDone && integrating) begin
      shadowBb_r <= chanCount[0];
      shadowIr_r <= chanCount[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shadowFull_r <= 1'b0;
    end else if (xfer && readHold) begin
      shadowFull_r <= 1'b1;
    end else if (!readHold) begin
      shadowFull_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      broadbandData_r <= lcv_pkg::DATA_RESET;
      infraredData_r  <= lcv_pkg::DATA_RESET;
      dataValid_r     <= 1'b0;
    end else if ((xfer || shadowFull_r) && !readHold) begin
      broadbandData_r <= shadowBb_r;
      infraredData_r  <= shadowIr_r;
      dataValid_r     <= 1'b1;
    end
  end

  // Window test on the broadband result, counted against the persistence setting.
  // A zero setting fires on every out-of-window result, never inside the window.
  assign outside     = (shadowBb_r > threshHigh) || (shadowBb_r < threshLow);
  assign persist_nxt = !outside ? 4'h0 :
                       (persistCnt_r == lcv_pkg::PERSIST_MAX) ? persistCnt_r :
                       persistCnt_r + 4'h1;
  assign fire        = outside && ((persistCode == lcv_pkg::PERSIST_EVERY) ||
                                   (persist_nxt >= persistCode));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      persistCnt_r <= 4'h0;
    end else if (xfer) begin
      persistCnt_r <= persist_nxt;
    end
  end

  // A new event in the clearing cycle keeps the interrupt raised.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      intActive_r <= 1'b0;
    end else if (xfer && fire) begin
      intActive_r <= 1'b1;
    end else if (intClear) begin
      intActive_r <= 1'b0;
    end
  end

  // The pin only ever drives low; the enable alone carries the interrupt.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      intPinOut_r <= 1'b0;
    end else begin
      intPinOut_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      deviceAddr_r <= lcv_pkg::BUS_ADDR_FLOAT;
    end else begin
      deviceAddr_r <= addrFor(addrSelLevel);
    end
  end

  assign broadbandData = broadbandData_r;
  assign infraredData  = infraredData_r;
  assign dataValid     = dataValid_r;
  assign intPinOut     = intPinOut_r;
  assign intPinOe      = intActive_r;
  assign deviceAddr    = deviceAddr_r;

endmodule

// [verification/lcv_conv_props.sv]
// Port checker for the light conversion sequencer.
// Assumes one core clock and the synchronous active-low reset of the top module.
`timescale 1ns/1ns
module lcv_conv_props #(
  parameter int unsigned INTEG_UNIT = 918
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  timingCode,
  input wire logic [15:0] threshLow,
  input wire logic [15:0] threshHigh,
  input wire logic        intClear,
  input wire logic        readHold,
  input wire logic [1:0]  addrSelLevel,
  input wire logic [15:0] broadbandData,
  input wire logic [15:0] infraredData,
  input wire logic        dataValid,
  input wire logic        intPinOut,
  input wire logic        intPinOe,
  input wire logic [6:0]  deviceAddr
);
  int fsMax;

  always_comb begin
    case (timingCode)
      2'h0: fsMax = 11 * INTEG_UNIT / 2 - 2;
      2'h1: fsMax = 81 * INTEG_UNIT / 2 - 2;
      default: fsMax = 322 * INTEG_UNIT / 2 - 2;
    endcase
    if (fsMax > 65535) fsMax = 65535;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  pin_low_only_a: assert property (intPinOut == 1'b0)
    else $error("interrupt pin driven high");
  int_holds_a: assert property (intPinOe && !intClear |=> intPinOe)
    else $error("interrupt dropped without a clear");
  int_fall_cause_a: assert property ($fell(intPinOe) |-> $past(intClear))
    else $error("interrupt fell without a clear");
  int_window_a: assert property ($rose(intPinOe) && !$past(readHold) |->
      broadbandData > $past(threshHigh) || broadbandData < $past(threshLow))
    else $error("interrupt raised inside the window");
  int_after_data_a: assert property (intPinOe |-> dataValid)
    else $error("interrupt before any result");
  data_frozen_a: assert property (!$stable(broadbandData) || !$stable(infraredData)
      |-> !$past(readHold))
    else $error("visible data changed while held");
  count_sat_a: assert property (dataValid |-> broadbandData <= fsMax && infraredData <= fsMax)
    else $error("count above full scale");
  addr_map_a: assert property ($stable(addrSelLevel) [*4] |-> deviceAddr ==
      (addrSelLevel == 2'h0 ? 7'h29 : addrSelLevel == 2'h2 ? 7'h49 : 7'h39))
    else $error("bus address does not match select pin");

  int_seen_c: cover property ($rose(intPinOe));
  hold_seen_c: cover property (readHold ##1 !readHold);
  sat_seen_c: cover property (dataValid && broadbandData == fsMax);
endmodule

// [verification/lcv_host_model.sv]
// Host firmware model that services the interrupt pin.
// Assumes the pin level already includes the board pull-up.
`timescale 1ns/1ns
module lcv_host_model (
  input  wire logic core_clk,
  input  wire logic clearEnable,
  input  wire logic intPin,
  output logic      intClear
);
  logic [2:0] waitCnt_r;

  initial begin
    intClear = 1'b0;
    waitCnt_r = 3'h0;
  end

  // A short service delay shows that the pin holds on its own until cleared.
  always @(posedge core_clk) begin
    if (!clearEnable || intPin || intClear) waitCnt_r <= 3'h0;
    else waitCnt_r <= waitCnt_r + 3'h1;
    intClear <= #5 (waitCnt_r == 3'h6);
  end
endmodule

// [verification/tb.sv]
// Self-checking bench for the light conversion sequencer.
// Assumes a scaled integration unit of 4 oscillator cycles to keep the run short.
`timescale 1ns/1ns
module tb;
  logic        core_clk, rst_n, powerOn, readHold, intClear, clearEn, dataValid;
  logic        intPinOut, intPinOe;
  logic [1:0]  timingCode, photoPulse, addrSelLevel;
  logic [15:0] threshLow, threshHigh, broadbandData, infraredData;
  logic [3:0]  persistCode;
  logic [6:0]  deviceAddr;
  wire         intPin = intPinOe ? intPinOut : 1'b1;
  int          fails, n_tests, cyc;

  lcv_conv_top #(.INTEG_UNIT(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .powerOn(powerOn), .timingCode(timingCode), .threshLow(threshLow),
    .threshHigh(threshHigh), .persistCode(persistCode), .intClear(intClear),
    .readHold(readHold), .photoPulse(photoPulse), .addrSelLevel(addrSelLevel),
    .broadbandData(broadbandData), .infraredData(infraredData), .dataValid(dataValid),
    .intPinOut(intPinOut), .intPinOe(intPinOe), .deviceAddr(deviceAddr));
  lcv_host_model host_u (.core_clk(core_clk), .clearEnable(clearEn), .intPin(intPin),
    .intClear(intClear));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic wait_bb(input logic [15:0] v, input int lim);
    int k;
    k = 0;
    while (broadbandData !== v && k < lim) begin tick(1); k++; end
  endtask
  task automatic wait_int(input int lim);
    int k;
    k = 0;
    while (intPinOe !== 1'b1 && k < lim) begin tick(1); k++; end
  endtask
  task automatic finish_test();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_addr();
    logic [6:0] exp [4] = '{7'h29, 7'h39, 7'h49, 7'h39};
    for (int i = 0; i < 4; i++) begin
      addrSelLevel = 2'(i);
      tick(4);
      check(deviceAddr, exp[i]);
    end
  endtask
  task automatic t_sat();
    check(dataValid, 1'b0);
    photoPulse = 2'h3;
    powerOn = 1'b1;
    wait_bb(16'h0014, 1400);
    check(dataValid, 1'b1);
    check(broadbandData, 16'h0014);
    check(infraredData, 16'h0014);
    check(intPinOe, 1'b0);
  endtask
  task automatic t_int();
    threshHigh = 16'h0014;
    tick(1200);
    check(intPinOe, 1'b0);
    threshHigh = 16'h000a;
    wait_int(1400);
    check(intPinOe, 1'b1);
    check(intPin, 1'b0);
    threshHigh = 16'hffff;
    tick(2500);
    check(intPinOe, 1'b1);
    clearEn = 1'b1;
    tick(20);
    check(intPin, 1'b1);
  endtask
  task automatic t_hold();
    readHold = 1'b1;
    photoPulse = 2'h0;
    tick(2500);
    check(broadbandData, 16'h0014);
    readHold = 1'b0;
    tick(3);
    check({broadbandData, infraredData}, 32'h0);
  endtask
  task automatic t_persist();
    clearEn = 1'b0;
    threshLow = 16'h0005;
    persistCode = 4'h2;
    tick(1100);
    check(intPinOe, 1'b0);
    wait_int(1400);
    check(intPinOe, 1'b1);
    threshLow = 16'h0000;
    persistCode = 4'h0;
    clearEn = 1'b1;
    tick(20);
  endtask
  task automatic t_time();
    logic [15:0] fs [3] = '{16'd20, 16'd160, 16'd642};
    int mult [3] = '{11, 81, 322};
    for (int c = 0; c < 3; c++) begin
      powerOn = 1'b0;
      photoPulse = 2'h1;
      timingCode = 2'(c);
      tick(2);
      powerOn = 1'b1;
      wait_bb(fs[c], mult[c] * 4 * 27 + 400);
      check(broadbandData, fs[c]);
      check(infraredData, 16'h0);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 70000) begin fails++; finish_test(); end
  end

  initial begin
    rst_n = 1'b0; powerOn = 1'b0; readHold = 1'b0; clearEn = 1'b0;
    timingCode = 2'h0; photoPulse = 2'h0; addrSelLevel = 2'h1;
    threshLow = 16'h0; threshHigh = 16'hffff; persistCode = 4'h0;
    fails = 0; n_tests = 0; cyc = 0;
    tick(16);
    rst_n = 1'b1;
    tick(2);
    t_addr();
    t_sat();
    t_int();
    t_hold();
    t_persist();
    t_time();
    finish_test();
  end
endmodule

bind lcv_conv_top lcv_conv_props #(.INTEG_UNIT(INTEG_UNIT)) props_u (.core_clk(core_clk),
  .rst_n(rst_n), .timingCode(timingCode), .threshLow(threshLow), .threshHigh(threshHigh),
  .intClear(intClear), .readHold(readHold), .addrSelLevel(addrSelLevel),
  .broadbandData(broadbandData), .infraredData(infraredData), .dataValid(dataValid),
  .intPinOut(intPinOut), .intPinOe(intPinOe), .deviceAddr(deviceAddr));
